/* flow_jump_defs.svh */
// timing, opcode, instruction length and reset value constants for the flow jump unit
`ifndef FLOW_JUMP_DEFS_SVH
`define FLOW_JUMP_DEFS_SVH
// ==========================================
// opcodes
`define OPC_INDIRECT_JUMP 8'h73
`define OPC_JUMP_BIT_CLEAR 8'h30
`define OPC_JUMP_CARRY_CLEAR 8'h50
// ==========================================
// lengths and machine cycles
`define LEN_INDIRECT 16'h0001
`define LEN_BIT_CLEAR 16'h0003
`define LEN_CARRY_CLEAR 16'h0002
`define EXEC_CYCLES 2'h2
// ==========================================
// reset values
`define RESET_PC_VALUE 16'h0000
`define RESET_BYTE_VALUE 8'h00
`endif

/* flow_jump_pkg.sv */
// types shared by the flow jump unit
package flow_jump_pkg;
  // ==========================================
  // instruction as presented by fetch
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } instr_s;
  // ==========================================
  // architectural state seen by the unit
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] acc;
    logic [15:0] data_pointer_reg;
    logic carry;
  } core_state_s;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_INDIRECT,
    OP_BIT_CLEAR,
    OP_CARRY_CLEAR
  } op_kind_e;
endpackage

/* flow_jump_unit.sv */
// execute unit for the indirect and conditional-clear jumps
`include "flow_jump_defs.svh"
module flow_jump_unit (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic ISSUE_VALID,
  input wire flow_jump_pkg::instr_s INSTR,
  input wire flow_jump_pkg::core_state_s STATE,
  input wire logic BIT_VALUE,
  output logic ISSUE_READY,
  output logic CLAIMED,
  output logic [7:0] BIT_ADDR,
  output logic BIT_RD,
  output logic PC_LOAD,
  output logic [15:0] PC_NEXT,
  output logic TAKEN,
  output logic BUSY
);
  // ==========================================
  // state and captured operands
  typedef enum logic [1:0] {IDLE, EXEC} st_e;
  st_e state_ff;
  st_e nxt_state;
  flow_jump_pkg::op_kind_e kind_ff;
  flow_jump_pkg::op_kind_e dec_kind;
  logic [15:0] pc_ff;
  logic [7:0] acc_ff;
  logic [15:0] data_pointer_ff;
  logic [7:0] rel_ff;
  logic [7:0] baddr_ff;
  logic carry_ff;
  logic [15:0] pc_out_ff;
  logic load_ff;
  logic taken_ff;
  logic [15:0] target;
  wire claim_op;
  wire accept;
  wire is_bit_clear;
  wire [7:0] rel_sel;
  wire exec_indirect;
  wire exec_bit_clear;
  wire exec_carry_clear;
  wire take_rel;
  wire taken_now;

  // ==========================================
  // decode helpers
  // one shared compare keeps decode and operand steering in step
  function automatic logic opcode_is(input logic [7:0] opc, input logic [7:0] pattern);
    opcode_is = (opc == pattern);
  endfunction
  function automatic flow_jump_pkg::op_kind_e decode_op(input logic [7:0] opc);
    if (opcode_is(opc, `OPC_INDIRECT_JUMP)) begin
      decode_op = flow_jump_pkg::OP_INDIRECT;
    end else if (opcode_is(opc, `OPC_JUMP_BIT_CLEAR)) begin
      decode_op = flow_jump_pkg::OP_BIT_CLEAR;
    end else if (opcode_is(opc, `OPC_JUMP_CARRY_CLEAR)) begin
      decode_op = flow_jump_pkg::OP_CARRY_CLEAR;
    end else begin
      decode_op = flow_jump_pkg::OP_NONE;
    end
  endfunction

  // ==========================================
  // decode
  assign dec_kind = decode_op(INSTR.opcode);
  assign claim_op = (dec_kind != flow_jump_pkg::OP_NONE);
  assign is_bit_clear = opcode_is(INSTR.opcode, `OPC_JUMP_BIT_CLEAR);
  // offset is byte 3 for bit-clear, byte 2 for carry-clear
  assign rel_sel = is_bit_clear ? INSTR.byte3 : INSTR.byte2;

  // ==========================================
  // issue handshake
  // no stall input: ready simply drops for the one exec cycle
  assign ISSUE_READY = (state_ff == IDLE);
  assign CLAIMED = ISSUE_VALID && claim_op;
  assign accept = ISSUE_READY && CLAIMED;
  assign BUSY = (state_ff == EXEC);

  // ==========================================
  // exec qualifiers
  assign exec_indirect = BUSY && (kind_ff == flow_jump_pkg::OP_INDIRECT);
  assign exec_bit_clear = BUSY && (kind_ff == flow_jump_pkg::OP_BIT_CLEAR);
  assign exec_carry_clear = BUSY && (kind_ff == flow_jump_pkg::OP_CARRY_CLEAR);

  // ==========================================
  // bit access
  // pure read; no write path exists, so the tested bit is never touched
  assign BIT_ADDR = baddr_ff;
  assign BIT_RD = exec_bit_clear;

  // ==========================================
  // branch condition
  // bit read live in the exec cycle, carry as it stood at issue
  assign take_rel = exec_bit_clear ? !BIT_VALUE
                  : exec_carry_clear ? !carry_ff
                  : 1'h0;
  assign taken_now = take_rel || exec_indirect;

  // ==========================================
  // arithmetic
  jump_target_calc u_calc (
    .kind(kind_ff),
    .pc(pc_ff),
    .acc(acc_ff),
    .data_pointer_reg(data_pointer_ff),
    .rel(rel_ff),
    .take_rel(take_rel),
    .target(target)
  );

  // ==========================================
  // two machine cycles: capture, then resolve
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IDLE: if (accept) nxt_state = EXEC;
      EXEC: nxt_state = IDLE;
      default: nxt_state = IDLE;
    endcase
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_ff <= IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================
  // operand capture
  // everything is latched at issue so fetch may move on at once
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      kind_ff <= flow_jump_pkg::OP_NONE;
    end else if (accept) begin
      kind_ff <= dec_kind;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pc_ff <= `RESET_PC_VALUE;
    end else if (accept) begin
      pc_ff <= STATE.pc;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      acc_ff <= `RESET_BYTE_VALUE;
    end else if (accept) begin
      acc_ff <= STATE.acc;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      data_pointer_ff <= `RESET_PC_VALUE;
    end else if (accept) begin
      data_pointer_ff <= STATE.data_pointer_reg;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      carry_ff <= 1'h0;
    end else if (accept) begin
      carry_ff <= STATE.carry;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      baddr_ff <= `RESET_BYTE_VALUE;
    end else if (accept) begin
      baddr_ff <= INSTR.byte2;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rel_ff <= `RESET_BYTE_VALUE;
    end else if (accept) begin
      rel_ff <= rel_sel;
    end
  end

  // ==========================================
  // result
  // acc, data pointer and flags have no write port here
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      load_ff <= 1'h0;
    end else begin
      load_ff <= BUSY;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pc_out_ff <= `RESET_PC_VALUE;
    end else if (BUSY) begin
      pc_out_ff <= target;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      taken_ff <= 1'h0;
    end else if (BUSY) begin
      taken_ff <= taken_now;
    end
  end

  // ==========================================
  // outputs
  assign PC_LOAD = load_ff;
  assign PC_NEXT = pc_out_ff;
  assign TAKEN = taken_ff && load_ff;
endmodule

/* flow_jump_unit_asserts.sv */
// concurrent checks on the flow jump unit ports
`include "flow_jump_defs.svh"
module flow_jump_unit_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic ISSUE_VALID,
  input wire flow_jump_pkg::instr_s INSTR,
  input wire flow_jump_pkg::core_state_s STATE,
  input wire logic ISSUE_READY,
  input wire logic CLAIMED,
  input wire logic [7:0] BIT_ADDR,
  input wire logic BIT_RD,
  input wire logic PC_LOAD,
  input wire logic [15:0] PC_NEXT,
  input wire logic TAKEN,
  input wire logic BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire go = ISSUE_VALID && ISSUE_READY && CLAIMED;
  wire [7:0] op = INSTR.opcode;
  wire [15:0] isum = {8'h00, STATE.acc} + STATE.data_pointer_reg;
  wire [15:0] npc2 = STATE.pc + 16'h0002;
  // ==========================================
  // properties
  a_accept_busy: assert property (go |=> BUSY && !ISSUE_READY) else $error("no exec after accept");
  a_load_after: assert property (go |-> ##2 PC_LOAD) else $error("load not two cycles after accept");
  a_load_cause: assert property (PC_LOAD |-> $past(BUSY)) else $error("load without exec");
  a_taken_load: assert property (TAKEN |-> PC_LOAD) else $error("taken without load");
  a_claim_dec: assert property (CLAIMED == (ISSUE_VALID && (op == `OPC_INDIRECT_JUMP ||
    op == `OPC_JUMP_BIT_CLEAR || op == `OPC_JUMP_CARRY_CLEAR))) else $error("bad decode");
  a_bit_addr: assert property (go && op == `OPC_JUMP_BIT_CLEAR |=>
    BIT_RD && BIT_ADDR == $past(INSTR.byte2)) else $error("bit read wrong");
  a_indirect_sum: assert property (go && op == `OPC_INDIRECT_JUMP |-> ##2
    TAKEN && PC_NEXT == $past(isum, 2)) else $error("indirect target wrong");
  a_carry_set: assert property (go && op == `OPC_JUMP_CARRY_CLEAR && STATE.carry |-> ##2
    !TAKEN && PC_NEXT == $past(npc2, 2)) else $error("carry set fallthrough wrong");
  // back to back issue is the hazard worth seeing
  cover property (go ##2 go);
  cover property (go && op == `OPC_JUMP_BIT_CLEAR ##2 TAKEN);
  cover property (ISSUE_VALID && !CLAIMED);
endmodule
bind flow_jump_unit flow_jump_unit_asserts i_chk (.CLOCK(CLOCK), .RST(RST), .ISSUE_VALID(ISSUE_VALID), .INSTR(INSTR),
  .STATE(STATE), .ISSUE_READY(ISSUE_READY), .CLAIMED(CLAIMED), .BIT_ADDR(BIT_ADDR), .BIT_RD(BIT_RD),
  .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .TAKEN(TAKEN), .BUSY(BUSY));

/* jump_target_calc.sv */
// target address arithmetic for the flow jump unit
`include "flow_jump_defs.svh"
module jump_target_calc (
  input wire flow_jump_pkg::op_kind_e kind,
  input wire logic [15:0] pc,
  input wire logic [7:0] acc,
  input wire logic [15:0] data_pointer_reg,
  input wire logic [7:0] rel,
  input wire logic take_rel,
  output logic [15:0] target
);
  // ==========================================
  // helpers
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction
  wire [15:0] seq_pc;
  wire [15:0] rel_pc;
  wire [15:0] ind_pc;
  // carry ripples through all 16 bits, sum wraps
  assign ind_pc = data_pointer_reg + {8'h00, acc};
  assign seq_pc = (kind == flow_jump_pkg::OP_BIT_CLEAR) ? pc + `LEN_BIT_CLEAR
                : (kind == flow_jump_pkg::OP_CARRY_CLEAR) ? pc + `LEN_CARRY_CLEAR
                : pc + `LEN_INDIRECT;
  assign rel_pc = seq_pc + sext8(rel);
  assign target = (kind == flow_jump_pkg::OP_INDIRECT) ? ind_pc
                : take_rel ? rel_pc : seq_pc;
endmodule

/* tb_flow_jump_unit.sv */
// random self-checking bench for the flow jump unit
`include "flow_jump_defs.svh"
module tb_flow_jump_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK, RST, ISSUE_VALID, BIT_VALUE, ISSUE_READY, PC_LOAD, TAKEN;
  logic [15:0] PC_NEXT;
  flow_jump_pkg::instr_s INSTR;
  flow_jump_pkg::core_state_s STATE;
  logic [16:0] q[$];
  logic [7:0] ops[5] = '{8'h73, 8'h30, 8'h50, 8'h20, 8'h51};
  int fails, total_checks, seed;
  flow_jump_unit i_dut (.CLOCK(CLOCK), .RST(RST), .ISSUE_VALID(ISSUE_VALID), .INSTR(INSTR), .STATE(STATE),
    .BIT_VALUE(BIT_VALUE), .ISSUE_READY(ISSUE_READY), .CLAIMED(), .BIT_ADDR(), .BIT_RD(), .PC_LOAD(PC_LOAD),
    .PC_NEXT(PC_NEXT), .TAKEN(TAKEN), .BUSY());
  initial begin
    CLOCK = 1'h0;
    forever #50 CLOCK = ~CLOCK;
  end
  // ==========================================
  // tasks
  task end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // unknown opcodes push nothing, so a stray load shows up as a queue miss
  task automatic go(input logic [7:0] op, input logic b);
    logic [15:0] rel;
    int n;
    INSTR = {op, 16'($random(seed))};
    STATE = 41'({$random(seed), $random(seed)});
    ISSUE_VALID = 1'h1;
    rel = op == `OPC_JUMP_BIT_CLEAR ? {{8{INSTR.byte3[7]}}, INSTR.byte3} : {{8{INSTR.byte2[7]}}, INSTR.byte2};
    if (op == `OPC_INDIRECT_JUMP) q.push_back({{8'h00, STATE.acc} + STATE.data_pointer_reg, 1'h1});
    if (op == `OPC_JUMP_BIT_CLEAR) q.push_back({STATE.pc + 16'h0003 + (b ? 16'h0000 : rel), !b});
    if (op == `OPC_JUMP_CARRY_CLEAR) q.push_back({npc(STATE.pc, STATE.carry, rel), !STATE.carry});
    for (n = 0; n < 8 && ISSUE_READY !== 1'h1; n++) @(negedge CLOCK);
    if (n == 8) begin
      fails++;
      $display("[ERR] %0t ready timeout", $time);
      end_sim;
    end
    @(negedge CLOCK);
    BIT_VALUE = b;
  endtask
  function automatic logic [15:0] npc(input logic [15:0] pc, input logic c, input logic [15:0] rel);
    return pc + 16'h0002 + (c ? 16'h0000 : rel);
  endfunction
  // ==========================================
  // stimulus and result watcher
  initial begin
    seed = 32'hACB8;
    fails = 0;
    total_checks = 0;
    RST = 1'h1;
    ISSUE_VALID = 1'h0;
    INSTR = '0;
    STATE = '0;
    BIT_VALUE = 1'h0;
    repeat (16) @(posedge CLOCK);
    @(negedge CLOCK);
    RST = 1'h0;
    for (int i = 0; i < 300; i++) go(ops[$unsigned($random(seed)) % 5], 1'($random(seed)));
    ISSUE_VALID = 1'h0;
    repeat (4) @(negedge CLOCK);
    total_checks++;
    if (q.size() != 0) begin
      fails++;
      $display("[ERR] %0t missing loads", $time);
    end
    end_sim;
  end
  // sampled mid-cycle, away from the edge that launches the result
  always @(negedge CLOCK) begin
    if (!RST && PC_LOAD === 1'h1) begin
      total_checks++;
      if (q.size() == 0 || {PC_NEXT, TAKEN} !== q.pop_front()) begin
        fails++;
        $display("[ERR] %0t target mismatch", $time);
      end
    end
  end
endmodule
